// ===== nvmcs_defines.vh
// Register map, field positions, reset values and command codes for the NVM command block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef NVMCS_DEFINES_VH
`define NVMCS_DEFINES_VH

`define NVMCS_ADDR_W          8
`define NVMCS_OFF_CLKDIV      8'h00
`define NVMCS_OFF_CONFIG      8'h04
`define NVMCS_OFF_STATUS      8'h08
`define NVMCS_OFF_PROT_STAT   8'h0c
`define NVMCS_OFF_PARAM_IDX   8'h10
`define NVMCS_OFF_VERSION     8'h14
`define NVMCS_OFF_IRQ_STAT    8'h18
`define NVMCS_OFF_IRQ_MASK    8'h1c
`define NVMCS_OFF_PARAM_BASE  8'h40
`define NVMCS_PARAM_WORDS     6

`define NVMCS_DIV_W           7
`define NVMCS_BIT_DIV_LOCK    7
`define NVMCS_BIT_DIV_LOADED  8

`define NVMCS_WS_LSB          0
`define NVMCS_WS_W            2
`define NVMCS_WS_RESET        2'h3
`define NVMCS_BIT_FORCE_DF    2

`define NVMCS_BIT_CMD_DONE    0
`define NVMCS_BIT_ACC_ERR     1
`define NVMCS_BIT_DBL_FAULT   2
`define NVMCS_BIT_WS_ACK      0

`define NVMCS_IRQ_W           3

`define NVMCS_CMD_PGM_PFLASH  8'h06
`define NVMCS_CMD_PGM_ONCE    8'h07
`define NVMCS_CMD_ERS_ALL     8'h08
`define NVMCS_CMD_ERS_BLOCK   8'h09
`define NVMCS_CMD_ERS_SECTOR  8'h0a
`define NVMCS_CMD_PGM_EEPROM  8'h11
`define NVMCS_CMD_ERS_EE_SECT 8'h12

`define NVMCS_VERSION_DEFAULT 16'h0001

`endif

// ===== nvmcs_top.v
// NVM command parameter array, command launch handshake, read-path wait states
// and divider/version registers behind an APB slave.
// Assumes a command engine and a flash array read port on the same clock,
// and a mode select strap arriving from a pin.
`timescale 1ns/10ps
`include "nvmcs_defines.vh"

module nvmcs_top #(
	parameter [15:0] VERSION_WORD = `NVMCS_VERSION_DEFAULT // Arbitrary neutral value
) (
	input  wire        i_ref_clk,
	input  wire        i_rst,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [7:0]  i_paddr,
	input  wire [31:0] i_pwdata,
	input  wire [3:0]  i_pstrb,
	output reg  [31:0] o_prdata,
	output wire        o_pready,
	output wire        o_pslverr,
	input  wire        i_special_mode,
	output reg         o_cmd_start,
	output wire [7:0]  o_command_code,
	output wire [23:0] o_cmd_addr,
	output wire [2:0]  o_cmd_word_count,
	output wire [6:0]  o_divider_value,
	input  wire        i_cmd_done,
	input  wire        i_result_we,
	input  wire [2:0]  i_result_idx,
	input  wire [15:0] i_result_data,
	input  wire        i_core_rd_req,
	output wire        o_core_stall,
	output reg         o_core_rd_ack,
	output reg  [31:0] o_core_rdata,
	output reg         o_core_rd_invalid,
	output reg         o_arr_rd_en,
	input  wire [31:0] i_arr_rdata,
	input  wire        i_arr_dbl_err,
	output wire        o_irq
);

	localparam NW = `NVMCS_PARAM_WORDS;
	localparam ST_IDLE = 1'b0;
	localparam ST_BUSY = 1'b1;

	reg  [15:0]              param_word [0:NW-1];
	reg  [2:0]               param_index;
	reg  [`NVMCS_DIV_W-1:0]  divider_value;
	reg                      divider_lock;
	reg                      divider_loaded;
	reg  [`NVMCS_WS_W-1:0]   waitstate_config;
	reg  [`NVMCS_WS_W-1:0]   ws_active;
	reg                      waitstate_ack;
	reg                      force_double_fault;
	reg                      command_complete_flag;
	reg                      access_error_flag;
	reg                      double_fault_flag;
	reg  [`NVMCS_IRQ_W-1:0]  irq_stat;
	reg  [`NVMCS_IRQ_W-1:0]  irq_mask;
	reg                      state;
	reg                      mode_meta;
	reg                      mode_sync;
	reg  [`NVMCS_WS_W-1:0]   ws_cnt;
	reg                      rd_busy;
	reg  [`NVMCS_IRQ_W-1:0]  next_irq_stat;

	wire                     wr_acc;
	wire                     rd_acc;
	wire                     in_array;
	wire [2:0]               arr_idx;
	wire                     mapped;
	wire                     launch;
	wire                     pgm_ers;
	wire                     refuse;
	wire                     dbl_event;
	wire                     rd_done;
	integer                  i;

	assign wr_acc   = i_psel & i_penable & i_pwrite;
	assign rd_acc   = i_psel & i_penable & ~i_pwrite;
	assign in_array = (i_paddr >= `NVMCS_OFF_PARAM_BASE) &&
		(i_paddr < (`NVMCS_OFF_PARAM_BASE + 8'h18)) && (i_paddr[1:0] == 2'h0);
	assign arr_idx  = i_paddr[4:2];
	assign mapped   = in_array ||
		(i_paddr == `NVMCS_OFF_CLKDIV)    || (i_paddr == `NVMCS_OFF_CONFIG)   ||
		(i_paddr == `NVMCS_OFF_STATUS)    || (i_paddr == `NVMCS_OFF_PROT_STAT) ||
		(i_paddr == `NVMCS_OFF_PARAM_IDX) || (i_paddr == `NVMCS_OFF_VERSION)  ||
		(i_paddr == `NVMCS_OFF_IRQ_STAT)  || (i_paddr == `NVMCS_OFF_IRQ_MASK);

	// Zero-wait slave; unmapped addresses answer with an error
	assign o_pready  = 1'b1;
	assign o_pslverr = i_psel & i_penable & ~mapped;

	// Command code in high byte of word 0, address spans word 0 low and word 1
	assign o_command_code   = param_word[0][15:8];
	assign o_cmd_addr       = {param_word[0][7:0], param_word[1]};
	assign o_cmd_word_count = param_index;
	assign o_divider_value  = divider_value;

	// Idle is checked too, so a repeated launch write while busy is harmless
	assign launch = wr_acc && (i_paddr == `NVMCS_OFF_STATUS) &&
		i_pwdata[`NVMCS_BIT_CMD_DONE] && command_complete_flag && (state == ST_IDLE);
	assign pgm_ers = (o_command_code == `NVMCS_CMD_PGM_PFLASH) ||
		(o_command_code == `NVMCS_CMD_PGM_ONCE)   || (o_command_code == `NVMCS_CMD_ERS_ALL) ||
		(o_command_code == `NVMCS_CMD_ERS_BLOCK)  || (o_command_code == `NVMCS_CMD_ERS_SECTOR) ||
		(o_command_code == `NVMCS_CMD_PGM_EEPROM) || (o_command_code == `NVMCS_CMD_ERS_EE_SECT);
	// A refused launch keeps the flag set, so no busy phase is seen
	assign refuse = launch & pgm_ers & ~divider_loaded;

	// Mode strap from a pin
	// Mode gates register writes and the clear of a forced fault, so two cycles of delay are harmless
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			mode_meta <= 1'b0;
			mode_sync <= 1'b0;
		end else begin
			mode_meta <= i_special_mode;
			mode_sync <= mode_meta;
		end
	end

	// Command launch and completion
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			state                 <= ST_IDLE;
			command_complete_flag <= 1'b1;
			o_cmd_start           <= 1'b0;
		end else begin
			o_cmd_start <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (launch && !refuse) begin
						command_complete_flag <= 1'b0;
						o_cmd_start           <= 1'b1;
						state                 <= ST_BUSY;
					end
				end
				ST_BUSY: begin
					if (i_cmd_done) begin
						command_complete_flag <= 1'b1;
						state                 <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Parameter array: byte lanes from the host, words from the engine
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			for (i = 0; i < NW; i = i + 1) begin
				param_word[i] <= 16'h0000;
			end
		end else if (state == ST_BUSY) begin
			// Host locked out; only results land here
			// Indices 6 and 7 are dropped, never folded onto a live word
			if (i_result_we && (i_result_idx < 3'h6)) begin
				param_word[i_result_idx] <= i_result_data;
			end
		end else if (wr_acc && in_array && command_complete_flag) begin
			if (i_pstrb[0]) begin
				param_word[arr_idx][7:0] <= i_pwdata[7:0];
			end
			if (i_pstrb[1]) begin
				param_word[arr_idx][15:8] <= i_pwdata[15:8];
			end
		end
	end

	// Index, divider, configuration
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			param_index        <= 3'h0;
			divider_value      <= {`NVMCS_DIV_W{1'b0}};
			divider_lock       <= 1'b0;
			divider_loaded     <= 1'b0;
			waitstate_config   <= `NVMCS_WS_RESET;
			force_double_fault <= 1'b0;
			irq_mask           <= {`NVMCS_IRQ_W{1'b0}};
		end else if (wr_acc) begin
			if (i_paddr == `NVMCS_OFF_PARAM_IDX && command_complete_flag && i_pstrb[0]) begin
				param_index <= i_pwdata[2:0];
			end
			// Special mode bypasses the lock so test code can retune
			if (i_paddr == `NVMCS_OFF_CLKDIV && (!divider_lock || mode_sync) &&
				command_complete_flag && i_pstrb[0]) begin
				divider_value  <= i_pwdata[`NVMCS_DIV_W-1:0];
				divider_lock   <= i_pwdata[`NVMCS_BIT_DIV_LOCK];
				divider_loaded <= 1'b1;
			end
			if (i_paddr == `NVMCS_OFF_CONFIG && i_pstrb[0]) begin
				waitstate_config <= i_pwdata[`NVMCS_WS_LSB +: `NVMCS_WS_W];
				// Forcing a fault is a test feature, special mode only
				if (mode_sync) begin
					force_double_fault <= i_pwdata[`NVMCS_BIT_FORCE_DF];
				end
			end
			if (i_paddr == `NVMCS_OFF_IRQ_MASK && i_pstrb[0]) begin
				irq_mask <= i_pwdata[`NVMCS_IRQ_W-1:0];
			end
		end else if (!mode_sync) begin
			// A forced fault left from test mode would pin the flag forever
			force_double_fault <= 1'b0;
		end
	end

	// Core read path with wait states
	assign rd_done      = rd_busy && (ws_cnt == ws_active);
	// Stall drops with the ack, the cycle the core takes its data
	assign o_core_stall = i_core_rd_req & ~o_core_rd_ack;
	assign dbl_event    = rd_done & i_arr_dbl_err;

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			rd_busy           <= 1'b0;
			ws_cnt            <= {`NVMCS_WS_W{1'b0}};
			o_core_rd_ack     <= 1'b0;
			o_core_rdata      <= 32'h00000000;
			o_core_rd_invalid <= 1'b0;
			o_arr_rd_en       <= 1'b0;
		end else begin
			o_core_rd_ack <= 1'b0;
			o_arr_rd_en   <= 1'b0;
			if (rd_done) begin
				rd_busy           <= 1'b0;
				o_core_rd_ack     <= 1'b1;
				o_core_rdata      <= i_arr_rdata;
				// Only a real array fault taints data, not the forced flag
				o_core_rd_invalid <= i_arr_dbl_err;
			end else if (rd_busy) begin
				ws_cnt <= ws_cnt + 1'b1;
			end else if (i_core_rd_req && !o_core_rd_ack) begin
				rd_busy     <= 1'b1;
				ws_cnt      <= {`NVMCS_WS_W{1'b0}};
				o_arr_rd_en <= 1'b1;
			end
		end
	end

	// Wait-state switch waits for an idle read path so no access sees a mixed count
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			ws_active     <= `NVMCS_WS_RESET;
			waitstate_ack <= 1'b1;
		end else if (wr_acc && i_paddr == `NVMCS_OFF_CONFIG && i_pstrb[0]) begin
			waitstate_ack <= 1'b0;
		end else if (!waitstate_ack && !rd_busy && !i_core_rd_req) begin
			ws_active     <= waitstate_config;
			waitstate_ack <= 1'b1;
		end
	end

	// Status flags; hardware set wins over software clear
	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			access_error_flag <= 1'b0;
			double_fault_flag <= 1'b0;
		end else begin
			if (refuse) begin
				access_error_flag <= 1'b1;
			end else if (wr_acc && i_paddr == `NVMCS_OFF_STATUS &&
				i_pwdata[`NVMCS_BIT_ACC_ERR]) begin
				access_error_flag <= 1'b0;
			end
			if (dbl_event || force_double_fault) begin
				double_fault_flag <= 1'b1;
			end else if (wr_acc && i_paddr == `NVMCS_OFF_STATUS &&
				i_pwdata[`NVMCS_BIT_DBL_FAULT]) begin
				double_fault_flag <= 1'b0;
			end
		end
	end

	// Interrupt status: cleared by reading it, new events survive the read
	always @* begin
		next_irq_stat = irq_stat;
		if (rd_acc && i_paddr == `NVMCS_OFF_IRQ_STAT) begin
			next_irq_stat = {`NVMCS_IRQ_W{1'b0}};
		end
		if (state == ST_BUSY && i_cmd_done) begin
			next_irq_stat[`NVMCS_BIT_CMD_DONE] = 1'b1;
		end
		if (refuse) begin
			next_irq_stat[`NVMCS_BIT_ACC_ERR] = 1'b1;
		end
		if (dbl_event) begin
			next_irq_stat[`NVMCS_BIT_DBL_FAULT] = 1'b1;
		end
	end

	always @(posedge i_ref_clk) begin
		if (i_rst) begin
			irq_stat <= {`NVMCS_IRQ_W{1'b0}};
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	assign o_irq = |(irq_stat & irq_mask);

	// Read mux; parameter words read as zero while a command runs
	always @* begin
		o_prdata = 32'h00000000;
		if (in_array) begin
			if (command_complete_flag) begin
				o_prdata[15:0] = param_word[arr_idx];
			end
		end else begin
			case (i_paddr)
				`NVMCS_OFF_CLKDIV: begin
					o_prdata[`NVMCS_DIV_W-1:0]       = divider_value;
					o_prdata[`NVMCS_BIT_DIV_LOCK]    = divider_lock;
					o_prdata[`NVMCS_BIT_DIV_LOADED]  = divider_loaded;
				end
				`NVMCS_OFF_CONFIG: begin
					o_prdata[`NVMCS_WS_LSB +: `NVMCS_WS_W] = waitstate_config;
					o_prdata[`NVMCS_BIT_FORCE_DF]          = force_double_fault;
				end
				`NVMCS_OFF_STATUS: begin
					o_prdata[`NVMCS_BIT_CMD_DONE]  = command_complete_flag;
					o_prdata[`NVMCS_BIT_ACC_ERR]   = access_error_flag;
					o_prdata[`NVMCS_BIT_DBL_FAULT] = double_fault_flag;
				end
				`NVMCS_OFF_PROT_STAT: begin
					o_prdata[`NVMCS_BIT_WS_ACK] = waitstate_ack;
				end
				`NVMCS_OFF_PARAM_IDX: begin
					o_prdata[2:0] = param_index;
				end
				`NVMCS_OFF_VERSION: begin
					// Upper bits reserved read zero
					// Values 4'h0 and 4'hf mean no version to software
					o_prdata[3:0] = VERSION_WORD[3:0];
				end
				`NVMCS_OFF_IRQ_STAT: begin
					o_prdata[`NVMCS_IRQ_W-1:0] = irq_stat;
				end
				`NVMCS_OFF_IRQ_MASK: begin
					o_prdata[`NVMCS_IRQ_W-1:0] = irq_mask;
				end
				default: begin
					o_prdata = 32'h00000000;
				end
			endcase
		end
	end

endmodule // nvmcs_top

// ===== nvmcs_checker.sv
// Checker for the NVM command block: launch, lock and core read timing.
// Assumes it is bound to nvmcs_top and sees only that module's ports.
`timescale 1ns/10ps
module nvmcs_checker (
	input wire        i_ref_clk,
	input wire        i_rst,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [7:0]  i_paddr,
	input wire [31:0] i_pwdata,
	input wire        o_cmd_start,
	input wire [7:0]  o_command_code,
	input wire        i_core_rd_req,
	input wire        o_core_stall,
	input wire        o_core_rd_ack,
	input wire [31:0] o_core_rdata,
	input wire        o_core_rd_invalid,
	input wire        o_arr_rd_en,
	input wire [31:0] i_arr_rdata,
	input wire        i_arr_dbl_err
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Status write with the launch bit set, as seen on the bus
	wire launch_wr = i_psel && i_penable && i_pwrite && i_paddr == 8'h08 && i_pwdata[0];
	sequence s_rd_go; o_arr_rd_en; endsequence
	sequence s_rd_end; ##[1:4] o_core_rd_ack; endsequence
	property p_rd_lat; s_rd_go |-> s_rd_end; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read ack late");
	property p_rd_req; o_arr_rd_en |-> $past(i_core_rd_req); endproperty
	a_rd_req: assert property (p_rd_req) else $error("read without request");
	property p_ack_pulse; o_core_rd_ack |=> !o_core_rd_ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_stall;
		i_core_rd_req && !o_core_rd_ack |-> o_core_stall ##[1:5] o_core_rd_ack;
	endproperty
	a_stall: assert property (p_stall) else $error("core not stalled");
	property p_inval; o_core_rd_ack |-> o_core_rd_invalid == $past(i_arr_dbl_err); endproperty
	a_inval: assert property (p_inval) else $error("invalid tag wrong");
	property p_data; o_core_rd_ack |-> o_core_rdata == $past(i_arr_rdata); endproperty
	a_data: assert property (p_data) else $error("read data wrong");
	property p_start;
		o_cmd_start |-> $past(launch_wr);
	endproperty
	a_start: assert property (p_start) else $error("start without launch");
	property p_start1; o_cmd_start |=> !o_cmd_start; endproperty
	a_start1: assert property (p_start1) else $error("start too long");
	property p_lock; o_cmd_start |=> $stable(o_command_code) [*4]; endproperty
	a_lock: assert property (p_lock) else $error("code changed while busy");
endmodule // nvmcs_checker
bind nvmcs_top nvmcs_checker u_chk (.*);

// ===== nvmcs_partner.sv
// Far-side model: command engine and flash array read port.
// Assumes the launch pulse and array read strobe share the bench clock.
`timescale 1ns/10ps
module nvmcs_partner #(
	parameter [15:0] RESULT = 16'hc3a5,
	parameter int    SPAN   = 16
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic        o_cmd_start,
	input  wire logic        o_arr_rd_en,
	input  wire logic [31:0] arr_val,
	input  wire logic        arr_dbl,
	output logic             i_cmd_done = 0,
	output logic             i_result_we = 0,
	output wire logic [2:0]  i_result_idx,
	output wire logic [15:0] i_result_data,
	output wire logic [31:0] i_arr_rdata,
	output wire logic        i_arr_dbl_err
);
	int run = 0;
	int hold = 0;
	wire live = hold != 0 || o_arr_rd_en;
	// Results go to word 2 so the launch fields stay put
	assign i_result_idx = 3'h2;
	assign i_result_data = RESULT;
	// Past the longest wait the array line no longer holds its value
	assign i_arr_rdata = live ? arr_val : ~arr_val;
	assign i_arr_dbl_err = live && arr_dbl;
	always @(posedge i_ref_clk) begin
		i_cmd_done <= run == 1;
		i_result_we <= run == 2;
		hold <= o_arr_rd_en ? 5 : (hold != 0 ? hold - 1 : 0);
		run <= i_rst ? 0 : o_cmd_start ? SPAN : (run != 0 ? run - 1 : 0);
	end
endmodule // nvmcs_partner

// ===== nvmcs_top_test.sv
// Self-checking bench for nvmcs_top: APB host, core reads, command runs.
// Assumes the partner model stands in for the engine and the array.
`timescale 1ns/10ps
module nvmcs_top_test;
	logic        i_ref_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [7:0]  i_paddr = 0, o_command_code;
	logic [31:0] i_pwdata = 0, o_prdata, o_core_rdata, i_arr_rdata, arr_val = 0, prd;
	logic [3:0]  i_pstrb = 0;
	logic        o_pready, o_pslverr, i_special_mode = 0, o_cmd_start, i_cmd_done;
	logic        i_result_we, i_core_rd_req = 0, o_core_stall, o_core_rd_ack;
	logic        o_core_rd_invalid, o_arr_rd_en, i_arr_dbl_err, o_irq, arr_dbl = 0, perr;
	logic [23:0] o_cmd_addr;
	logic [2:0]  o_cmd_word_count, i_result_idx;
	logic [6:0]  o_divider_value;
	logic [15:0] i_result_data;
	logic [31:0] seed = 32'h60b8;
	int          num_errors = 0, samples_checked = 0, tn = 0, model[6], n, w;
	nvmcs_top dut (.*);
	nvmcs_partner u_far (.*);
	always #5 i_ref_clk = ~i_ref_clk;
	function logic [31:0] xs;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task hang;
		num_errors++;
		test_done;
	endtask
	task fin;
		$display("test %0d done at %0t", tn++, $time);
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge i_ref_clk);
		i_psel <= 1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		i_pstrb <= s;
		@(posedge i_ref_clk);
		i_penable <= 1;
		for (k = 0; k < 20; k++) begin
			@(posedge i_ref_clk);
			if (o_pready === 1) break;
		end
		if (k == 20) hang;
		prd = o_prdata;
		perr = o_pslverr;
		i_psel <= 0;
		i_penable <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d, 4'hf);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0, 4'hf);
		chk(prd, e);
	endtask
	task core(input int ws, input logic dbl);
		int k;
		arr_val <= xs();
		arr_dbl <= dbl;
		i_core_rd_req <= 1;
		for (k = 1; k < 20; k++) begin
			@(posedge i_ref_clk);
			if (o_core_rd_ack === 1) break;
		end
		if (k == 20) hang;
		i_core_rd_req <= 0;
		chk(k, ws + 3);
		chk(o_core_rdata, arr_val);
		chk(o_core_rd_invalid, dbl);
	endtask
	initial begin
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 0;
		rd(8'h00, 0);
		rd(8'h04, 3);
		rd(8'h08, 1);
		rd(8'h0c, 1);
		rd(8'h14, 1);
		fin;
		for (n = 0; n < 6; n++) begin
			w = xs();
			apb(1, 8'(8'h40 + 4 * n), w, 4'h1);
			apb(1, 8'(8'h40 + 4 * n), ~w, 4'h2);
			model[n] = {~w[15:8], w[7:0]};
		end
		for (n = 0; n < 6; n++) rd(8'(8'h40 + 4 * n), model[n]);
		apb(0, 8'h30, 0, 4'hf);
		chk(perr, 1);
		fin;
		wr(8'h1c, 7);
		wr(8'h40, 32'h06ab);
		wr(8'h10, 1);
		wr(8'h08, 1);
		rd(8'h08, 3);
		chk(o_irq, 1);
		rd(8'h18, 2);
		@(negedge i_ref_clk);
		chk(o_irq, 0);
		wr(8'h08, 2);
		wr(8'h00, 32'h91);
		rd(8'h00, 32'h191);
		wr(8'h00, 32'h22);
		rd(8'h00, 32'h191);
		chk(o_divider_value, 7'h11);
		fin;
		w = xs();
		wr(8'h40, 32'h09ab);
		wr(8'h44, w);
		wr(8'h10, 1);
		wr(8'h08, 1);
		rd(8'h08, 0);
		chk(o_command_code, 8'h09);
		chk(o_cmd_addr, {8'hab, w[15:0]});
		chk(o_cmd_word_count, 1);
		wr(8'h44, ~w);
		wr(8'h10, 5);
		rd(8'h44, 0);
		for (n = 0; n < 40 && o_irq !== 1; n++) @(posedge i_ref_clk);
		if (n == 40) hang;
		rd(8'h44, w[15:0]);
		rd(8'h48, 32'hc3a5);
		rd(8'h18, 1);
		chk(o_cmd_word_count, 1);
		fin;
		core(3, 1);
		for (w = 0; w < 4; w++) begin
			wr(8'h04, w);
			rd(8'h0c, 1);
			core(w, w[0]);
		end
		rd(8'h18, 4);
		fin;
		i_special_mode <= 1;
		repeat (3) @(posedge i_ref_clk);
		wr(8'h00, 32'hb3);
		rd(8'h00, 32'h1b3);
		wr(8'h08, 4);
		rd(8'h08, 1);
		wr(8'h04, 4);
		rd(8'h08, 5);
		core(0, 0);
		rd(8'h18, 0);
		fin;
		test_done;
	end
endmodule // nvmcs_top_test
